// ### core/shunt_monitor_result_regs.sv
// register file of the current, voltage and power monitor: results, limit, ids
// assumes the serial engine and the converter run on mclk_i and present
// one-cycle request and sample strobes; the serial protocol itself lives outside
`timescale 1ns/1ps
`default_nettype none
module shunt_monitor_result_regs #(
	parameter logic [15:0]             MAKER_CODE = 16'h1234,   // arbitrary value
	parameter logic [shunt_pkg::PART_W-1:0] PART_CODE = 13'h0abc // arbitrary value
) (
	input  wire logic                mclk_i,         // 25 MHz clock
	input  wire logic                srst_i,         // sync reset, high
	input  wire shunt_pkg::reg_req_s req_i,          // register access strobe
	output logic [15:0]              rdata_o,        // read data, next cycle
	output logic                     rvalid_o,       // read data valid pulse
	input  wire shunt_pkg::sample_s  sense_smp_i,    // signed sense conversion
	input  wire shunt_pkg::sample_s  supply_smp_i,   // supply conversion
	output logic                     input_span_select_o, // converter range select
	output logic [15:0]              config_o,       // whole config word to converter
	output logic                     limit_exceeded_o, // selected limit crossed
	output logic                     math_overflow_flag_o, // sticky overflow
	output logic                     calc_done_o     // current and power updated
);
	import shunt_pkg::*;

	// register state
	logic [15:0]        config_q;
	logic [15:0]        cal_q;
	logic [15:0]        mask_q;
	logic [15:0]        limit_q;
	logic signed [15:0] sense_q;
	logic [15:0]        supply_q;
	logic               overflow_q;
	logic               aff_q;
	logic [15:0]        rdata_q;
	logic               rvalid_q;
	logic               pwr_start_q;

	// arithmetic results
	logic signed [15:0] current_w;
	logic               cur_overflow_w;
	logic               cur_done_w;
	logic [15:0]        power_w;
	logic               pwr_overflow_w;

	// write and read decode
	logic wr_config;
	logic wr_cal;
	logic wr_mask;
	logic wr_limit;
	logic rd_mask;

	assign wr_config = req_i.we & (req_i.addr == CONFIG_OFS);
	assign wr_cal    = req_i.we & (req_i.addr == CAL_OFS);
	assign wr_mask   = req_i.we & (req_i.addr == MASK_OFS);
	assign wr_limit  = req_i.we & (req_i.addr == LIMIT_OFS);
	assign rd_mask   = req_i.re & (req_i.addr == MASK_OFS);

	// writable fields of the mask word: the five limit selects only
	localparam logic [15:0] MASK_WR = 16'hf800;

	// configuration word
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			config_q <= CONFIG_RST;
		else if (wr_config)
			config_q <= req_i.wdata;
	end

	// calibration: the top bit is reserved and held at zero
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			cal_q <= CAL_RST;
		else if (wr_cal)
			cal_q <= {1'b0, req_i.wdata[CAL_W-1:0]};
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			mask_q <= MASK_RST;
		else if (wr_mask)
			mask_q <= req_i.wdata & MASK_WR;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			limit_q <= LIMIT_RST;
		else if (wr_limit)
			limit_q <= req_i.wdata;
	end

	// conversion results
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			sense_q <= RESULT_RST;
		else if (sense_smp_i.valid)
			sense_q <= $signed(sense_smp_i.data);
	end

	// the top bit is forced low so the supply count can never read negative
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			supply_q <= RESULT_RST;
		else if (supply_smp_i.valid)
			supply_q <= {1'b0, supply_smp_i.data[14:0]};
	end

	// current follows each sense sample using the raw incoming count
	current_calc u_current (
		.mclk_i   (mclk_i),
		.srst_i   (srst_i),
		.start_i  (sense_smp_i.valid),
		.sense_i  ($signed(sense_smp_i.data)),
		.cal_i    (cal_q[CAL_W-1:0]),
		.result_o (current_w),
		.overflow_o (cur_overflow_w),
		.done_o   (cur_done_w)
	);

	// the done flag waits one cycle so it lands with the power result; power starts on the current done pulse
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			pwr_start_q <= 1'b0;
		else
			pwr_start_q <= cur_done_w;
	end

	power_calc u_power (
		.mclk_i    (mclk_i),
		.srst_i    (srst_i),
		.start_i   (cur_done_w),
		.current_i (current_w),
		.supply_i  (supply_q),
		.result_o  (power_w),
		.overflow_o (pwr_overflow_w)
	);

	// overflow is sticky until the mask word is read; a new overflow in the
	// read cycle wins so it is never lost
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			overflow_q <= 1'b0;
		else if (cur_overflow_w | pwr_overflow_w)
			overflow_q <= 1'b1;
		else if (rd_mask)
			overflow_q <= 1'b0;
	end

	// limit comparison, each in the format of the compared result
	logic sense_over;
	logic sense_under;
	logic supply_over;
	logic supply_under;
	logic power_over;
	logic limit_hit;

	assign sense_over   = mask_q[SEL_SOL_BIT] & (sense_q > $signed(limit_q));
	assign sense_under  = mask_q[SEL_SUL_BIT] & (sense_q < $signed(limit_q));
	assign supply_over  = mask_q[SEL_BOL_BIT] & (supply_q > limit_q);
	assign supply_under = mask_q[SEL_BUL_BIT] & (supply_q < limit_q);
	assign power_over   = mask_q[SEL_POL_BIT] & (power_w > limit_q);
	assign limit_hit    = sense_over | sense_under | supply_over | supply_under | power_over;

	// limit flag follows the comparison; it is a plain level, no latching mode
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			aff_q <= 1'b0;
		else
			aff_q <= limit_hit;
	end

	// read mux
	logic [15:0] mask_rd;
	logic [15:0] part_rd;
	logic [15:0] rd_mux;

	assign mask_rd = (mask_q & MASK_WR)
	               | (16'h0001 << AFF_BIT) & {16{aff_q}}
	               | (16'h0001 << OVERFLOW_BIT) & {16{overflow_q}};
	assign part_rd = {PART_CODE, 3'b000};

	always_comb begin
		unique case (req_i.addr)
			CONFIG_OFS:  rd_mux = config_q;
			SENSE_OFS:   rd_mux = sense_q;
			SUPPLY_OFS:  rd_mux = supply_q;
			POWER_OFS:   rd_mux = power_w;
			CURRENT_OFS: rd_mux = current_w;
			CAL_OFS:     rd_mux = cal_q;
			MASK_OFS:    rd_mux = mask_rd;
			LIMIT_OFS:   rd_mux = limit_q;
			MAKER_OFS:   rd_mux = MAKER_CODE;
			PART_OFS:    rd_mux = part_rd;
			default:     rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			if (req_i.re)
				rdata_q <= rd_mux;
			rvalid_q <= req_i.re;
		end
	end

	// outputs
	assign rdata_o              = rdata_q;
	assign rvalid_o             = rvalid_q;
	assign config_o             = config_q;
	assign input_span_select_o  = config_q[SPAN_BIT];
	assign limit_exceeded_o     = aff_q;
	assign math_overflow_flag_o = overflow_q;
	assign calc_done_o          = pwr_start_q;

endmodule : shunt_monitor_result_regs
`default_nettype wire

// ### core/shunt_pkg.sv
// constants, register map and carrier types for the shunt monitor register block
// assumes one 25 MHz clock domain shared with the serial engine and the converter
package shunt_pkg;

	// register pointer offsets (8-bit pointer)
	localparam logic [7:0] CONFIG_OFS   = 8'h00;
	localparam logic [7:0] SENSE_OFS    = 8'h01;
	localparam logic [7:0] SUPPLY_OFS   = 8'h02;
	localparam logic [7:0] POWER_OFS    = 8'h03;
	localparam logic [7:0] CURRENT_OFS  = 8'h04;
	localparam logic [7:0] CAL_OFS      = 8'h05;
	localparam logic [7:0] MASK_OFS     = 8'h06;
	localparam logic [7:0] LIMIT_OFS    = 8'h07;
	localparam logic [7:0] MAKER_OFS    = 8'h3e;
	localparam logic [7:0] PART_OFS     = 8'h3f;

	// reset values
	localparam logic [15:0] CONFIG_RST  = 16'h0000;
	localparam logic [15:0] CAL_RST     = 16'h0000;
	localparam logic [15:0] MASK_RST    = 16'h0000;
	localparam logic [15:0] LIMIT_RST   = 16'h0000;
	localparam logic [15:0] RESULT_RST  = 16'h0000;

	// field positions
	localparam int SPAN_BIT      = 12;  // config: input_span_select
	localparam int CAL_W         = 15;  // calibration: bits 14-0, bit 15 reads zero
	localparam int SEL_SOL_BIT   = 15;  // mask: sense over limit
	localparam int SEL_SUL_BIT   = 14;  // mask: sense under limit
	localparam int SEL_BOL_BIT   = 13;  // mask: supply over limit
	localparam int SEL_BUL_BIT   = 12;  // mask: supply under limit
	localparam int SEL_POL_BIT   = 11;  // mask: power over limit
	localparam int AFF_BIT       = 4;   // mask: limit function flag (read only)
	localparam int OVERFLOW_BIT  = 2;   // mask: math_overflow_flag (read only)
	localparam int PART_LSB      = 3;   // part identification field 15-3
	localparam int PART_W        = 13;

	// arithmetic normalisation shifts
	localparam int CUR_SHIFT     = 11;
	localparam int PWR_SHIFT     = 8;

	// host-side register access as presented by the serial engine
	typedef struct packed {
		logic        we;
		logic        re;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_s;

	// one finished conversion from the converter
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} sample_s;

endpackage : shunt_pkg

// ### core/current_calc.sv
// current result: signed sense count times calibration, normalised and saturated
// assumes start_i is a one-cycle pulse on the clock of the register block
`timescale 1ns/1ps
`default_nettype none
module current_calc (
	input  wire logic               mclk_i,   // 25 MHz clock
	input  wire logic               srst_i,   // sync reset, high
	input  wire logic               start_i,  // new sense sample
	input  wire logic signed [15:0] sense_i,  // signed sense count
	input  wire logic [shunt_pkg::CAL_W-1:0] cal_i, // scale factor
	output logic signed [15:0]      result_o, // saturated current
	output logic                    overflow_o, // overflow pulse
	output logic                    done_o    // result updated pulse
);
	import shunt_pkg::*;

	logic signed [31:0] prod;
	logic signed [31:0] scaled;
	logic               too_big;
	logic               too_small;
	logic signed [15:0] sat;

	assign prod      = sense_i * $signed({1'b0, cal_i});
	assign scaled    = prod >>> CUR_SHIFT;
	assign too_big   = (scaled > 32'sd32767);
	assign too_small = (scaled < -32'sd32768);
	// zero calibration gives a zero product, so the result is zero
	assign sat       = (cal_i == '0) ? 16'sh0000 :
	                   too_big       ? 16'sh7fff :
	                   too_small     ? 16'sh8000 : scaled[15:0];

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			result_o <= 16'sh0000;
			overflow_o <= 1'b0;
			done_o   <= 1'b0;
		end else begin
			if (start_i)
				result_o <= sat;
			overflow_o <= start_i & (too_big | too_small);
			done_o <= start_i;
		end
	end
endmodule : current_calc
`default_nettype wire

// ### core/power_calc.sv
// power result: magnitude of current times supply count, normalised and saturated
// assumes start_i pulses in the same cycle that a fresh current result appears
`timescale 1ns/1ps
`default_nettype none
module power_calc (
	input  wire logic               mclk_i,    // 25 MHz clock
	input  wire logic               srst_i,    // sync reset, high
	input  wire logic               start_i,   // recompute pulse
	input  wire logic signed [15:0] current_i, // current result
	input  wire logic [15:0]        supply_i,  // supply count
	output logic [15:0]             result_o,  // saturated power
	output logic                    overflow_o // overflow pulse
);
	import shunt_pkg::*;

	logic [16:0] mag;
	logic [32:0] prod;
	logic [32:0] scaled;
	logic        too_big;

	// power is unsigned, so the current direction is dropped
	assign mag     = current_i[15] ? (17'h00000 - {current_i[15], current_i}) : {1'b0, current_i};
	assign prod    = {16'h0000, mag} * {17'h00000, supply_i};
	assign scaled  = prod >> PWR_SHIFT;
	assign too_big = (scaled[32:16] != 17'h00000);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			result_o <= 16'h0000;
			overflow_o <= 1'b0;
		end else begin
			if (start_i)
				result_o <= too_big ? 16'hffff : scaled[15:0];
			overflow_o <= start_i & too_big;
		end
	end
endmodule : power_calc
`default_nettype wire

// ### testbench/shunt_monitor_result_regs_checker.sv
// port assertions of the monitor register block
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module shunt_monitor_result_regs_checker
	import shunt_pkg::*;
#(
	parameter logic [15:0]       MAKER_CODE = 16'h1234, // arbitrary value
	parameter logic [PART_W-1:0] PART_CODE  = 13'h0abc  // arbitrary value
) (
	input wire logic        mclk_i,               // clock
	input wire logic        srst_i,               // sync reset
	input wire reg_req_s    req_i,                // register request
	input wire logic [15:0] rdata_o,              // read data
	input wire logic        rvalid_o,             // read valid
	input wire sample_s     sense_smp_i,          // sense sample
	input wire sample_s     supply_smp_i,         // supply sample
	input wire logic        input_span_select_o,  // range select
	input wire logic        math_overflow_flag_o, // overflow flag
	input wire logic        calc_done_o           // results updated
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	wire logic [7:0] ra = req_i.addr;
	logic [15:0]     sen_q;
	logic [15:0]     sup_q;
	logic [15:0]     lim_q;
	// shadow copies of the last raw sample or limit write; sup_q keeps the supply top bit
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			{sen_q, sup_q, lim_q} <= '0;
		end else begin
			if (sense_smp_i.valid)
				sen_q <= sense_smp_i.data;
			if (supply_smp_i.valid)
				sup_q <= supply_smp_i.data;
			if (req_i.we && ra == LIMIT_OFS)
				lim_q <= req_i.wdata;
		end
	end
	property p_maker;
		req_i.re && ra == MAKER_OFS |=> rvalid_o && rdata_o == MAKER_CODE;
	endproperty
	a_maker: assert property (p_maker) else $error("maker code wrong");
	property p_part;
		req_i.re && ra == PART_OFS |=> rvalid_o && rdata_o == {PART_CODE, 3'h0};
	endproperty
	a_part: assert property (p_part) else $error("part code wrong");
	property p_limit;
		req_i.re && ra == LIMIT_OFS |=> rdata_o == lim_q;
	endproperty
	a_limit: assert property (p_limit) else $error("limit readback wrong");
	property p_span;
		req_i.we && ra == CONFIG_OFS |=> input_span_select_o == $past(req_i.wdata[SPAN_BIT]);
	endproperty
	a_span: assert property (p_span) else $error("span select not taken");
	property p_sense;
		req_i.re && ra == SENSE_OFS && !sense_smp_i.valid |=> rdata_o == sen_q;
	endproperty
	a_sense: assert property (p_sense) else $error("sense readback wrong");
	property p_supply;
		req_i.re && ra == SUPPLY_OFS && !supply_smp_i.valid |=> rdata_o == {1'b0, sup_q[14:0]};
	endproperty
	a_supply: assert property (p_supply) else $error("supply readback wrong");
	property p_done;
		sense_smp_i.valid |-> ##2 calc_done_o;
	endproperty
	a_done: assert property (p_done) else $error("no result update");
	property p_overflow_hold;
		math_overflow_flag_o && !(req_i.re && ra == MASK_OFS) |=> math_overflow_flag_o;
	endproperty
	a_overflow_hold: assert property (p_overflow_hold) else $error("overflow flag lost");
endmodule : shunt_monitor_result_regs_checker
bind shunt_monitor_result_regs shunt_monitor_result_regs_checker #(
	.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)
) i_shunt_monitor_result_regs_checker (.mclk_i, .srst_i, .req_i, .rdata_o, .rvalid_o,
	.sense_smp_i, .supply_smp_i, .input_span_select_o, .math_overflow_flag_o, .calc_done_o);
`default_nettype wire

// ### testbench/host_model.sv
// host model: drives register request strobes and collects read answers
// assumes the block samples requests on the rising edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
module host_model
	import shunt_pkg::*;
(
	input  wire logic        mclk_i,   // clock
	output var  reg_req_s    req_o,    // request strobe
	input  wire logic [15:0] rdata_i,  // read data
	input  wire logic        rvalid_i  // read valid
);
	initial req_o = '0;
	// start one access; consecutive calls give back-to-back requests
	task automatic put(input logic we, input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		req_o <= '{we: we, re: !we, addr: a, wdata: d};
	endtask : put
	// release the strobe, then take the answer once the read edge has landed
	task automatic fin(output logic [16:0] q);
		@(posedge mclk_i);
		req_o <= '0;
		@(negedge mclk_i);
		q = {rvalid_i, rdata_i};
	endtask : fin
	function automatic logic [15:0] cal_of(input real lsb, input real rsh, input logic span);
		real c;
		c = 0.00512 / (lsb * rsh);
		if (span)
			c = c / 4.0;
		return 16'(int'(c));
	endfunction : cal_of
endmodule : host_model
`default_nettype wire

// ### testbench/test_shunt_monitor_result_regs.sv
// bench of the monitor register block: host accesses and converter samples
// assumes host_model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h, wanted %h", $time, a, e); end end
module test_shunt_monitor_result_regs;
	import shunt_pkg::*;
	localparam logic [15:0] MAKER = 16'h5a3c; // arbitrary value
	localparam logic [12:0] PART  = 13'h1357; // arbitrary value
	// 8 A peak over 2^15 is about 0.24 mA; 1 mA stays under 8x that
	localparam real         STEP  = 1.0e-3;
	localparam real         RSH   = 0.01;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	sample_s     sen = '0;
	sample_s     sup = '0;
	reg_req_s    req;
	logic [15:0] rdata, cfg;
	logic        rvalid, span, lim, oflow, done;
	logic [16:0] q;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #20 mclk_i = ~mclk_i;
	shunt_monitor_result_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_shunt_monitor_result_regs (
		.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
		.sense_smp_i(sen), .supply_smp_i(sup), .input_span_select_o(span), .config_o(cfg),
		.limit_exceeded_o(lim), .math_overflow_flag_o(oflow), .calc_done_o(done));
	host_model i_host_model (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host_model.put(1'b1, a, d);
		i_host_model.fin(q);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		i_host_model.put(1'b0, a, 16'h0000);
		i_host_model.fin(q);
		`CHK(q, {1'b1, e})
	endtask : rchk
	// supply goes one edge ahead of sense so power sees the fresh supply
	task automatic conv(input logic [15:0] s, input logic [15:0] v);
		@(posedge mclk_i);
		sup <= '{valid: 1'b1, data: v};
		@(posedge mclk_i);
		sup <= '0;
		sen <= '{valid: 1'b1, data: s};
		@(posedge mclk_i);
		sen <= '0;
		for (int k = 0; k < 8 && done !== 1'b1; k++)
			@(negedge mclk_i);
		`CHK(done, 1'b1)
	endtask : conv
	initial begin
		repeat (6) @(posedge mclk_i);
		srst_i <= 1'b0;
		rchk(LIMIT_OFS, 16'h0000);
		rchk(8'h55, 16'h0000);
		wr(MAKER_OFS, 16'h0000);
		rchk(MAKER_OFS, MAKER);
		rchk(PART_OFS, {PART, 3'h0});
		i_host_model.put(1'b1, LIMIT_OFS, 16'h8001);
		i_host_model.put(1'b0, LIMIT_OFS, 16'h0000);
		i_host_model.fin(q);
		`CHK(q, {1'b1, 16'h8001})
		$display("test registers finished");
		conv(16'hff38, 16'hffff);
		rchk(SENSE_OFS, 16'hff38);
		rchk(SUPPLY_OFS, 16'h7fff);
		wr(CAL_OFS, i_host_model.cal_of(STEP, RSH, 1'b0));
		conv(16'h03e8, 16'h07d0);
		rchk(CURRENT_OFS, 16'h00fa);
		rchk(POWER_OFS, 16'h07a1);
		conv(16'hfc18, 16'h07d0);
		rchk(CURRENT_OFS, 16'hff06);
		wr(CONFIG_OFS, 16'h1000);
		@(negedge mclk_i);
		`CHK(span, 1'b1)
		`CHK(cfg, 16'h1000)
		rchk(CONFIG_OFS, 16'h1000);
		wr(CAL_OFS, i_host_model.cal_of(STEP, RSH, 1'b1));
		conv(16'h0fa0, 16'h07d0);
		rchk(CURRENT_OFS, 16'h00fa);
		wr(CAL_OFS, 16'h0000);
		conv(16'h03e8, 16'h07d0);
		rchk(CURRENT_OFS, 16'h0000);
		$display("test results finished");
		wr(MASK_OFS, 16'h8000);
		wr(LIMIT_OFS, 16'hfff0);
		conv(16'hfff8, 16'h0000);
		`CHK(lim, 1'b1)
		conv(16'hffec, 16'h0000);
		`CHK(lim, 1'b0)
		// a positive sense count above a negative limit only trips a signed compare
		conv(16'h0008, 16'h0000);
		`CHK(lim, 1'b1)
		wr(MASK_OFS, 16'h4000);
		conv(16'hffec, 16'h0000);
		`CHK(lim, 1'b1)
		wr(MASK_OFS, 16'h2000);
		wr(LIMIT_OFS, 16'h0100);
		conv(16'h0000, 16'h0200);
		`CHK(lim, 1'b1)
		wr(MASK_OFS, 16'h1000);
		conv(16'h0000, 16'h0080);
		`CHK(lim, 1'b1)
		wr(MASK_OFS, 16'h0800);
		wr(CAL_OFS, 16'h0200);
		conv(16'h03e8, 16'h07d0);
		// power lands with the done pulse, so the flag follows one cycle later
		`CHK(lim, 1'b0)
		@(negedge mclk_i);
		`CHK(lim, 1'b1)
		wr(CAL_OFS, 16'h7fff);
		conv(16'h7fff, 16'h0010);
		`CHK(oflow, 1'b1)
		rchk(CURRENT_OFS, 16'h7fff);
		i_host_model.put(1'b0, MASK_OFS, 16'h0000);
		i_host_model.fin(q);
		`CHK(q[2], 1'b1)
		`CHK(oflow, 1'b0)
		$display("test limit and overflow finished");
		print_verdict();
	end
endmodule : test_shunt_monitor_result_regs
`default_nettype wire
